// File: verilog/dmem_pkg.sv
// constants and types shared by the data memory decoder
package dmem_pkg;
  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [7:0] BANK_TOP = 8'h1F;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
  localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hD0;
  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
  localparam logic [7:0] PROGRAM_STATUS_WORD_RESET = 8'h00;
  localparam int BANK_SELECT_LOW_POS = 3;
  localparam int BANK_SELECT_HIGH_POS = 4;
  // ----------------------------------------------------------------
  // access kinds from the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_DIRECT = 3'b000,
    KIND_INDIRECT = 3'b001,
    KIND_BIT = 3'b010,
    KIND_REG = 3'b011,
    KIND_PUSH = 3'b100,
    KIND_POP = 3'b101,
    KIND_ONCHIP_EXTERNAL_RAM = 3'b110,
    KIND_NONE = 3'b111
  } acc_kind_t;
endpackage

// File: verilog/data_memory_sfr_decoder.sv
// data memory, stack and special function register decoder
`timescale 1ns/1ps
module data_memory_sfr_decoder
  import dmem_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire acc_kind_t acc_kind,
  input wire logic acc_write,
  input wire logic [7:0] acc_addr,
  input wire logic [15:0] acc_xaddr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_wbit,
  input wire logic program_store_write_enable,
  input wire logic program_store_erase_enable,
  input wire logic [7:0] sfr_rdata,
  output logic sfr_valid,
  output logic sfr_write,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [7:0] rd_data_ff,
  output logic rd_bit_ff,
  output logic rd_valid_ff,
  output logic [7:0] ram_addr_ff,
  output logic [7:0] stack_pointer_ff,
  output logic [7:0] program_status_word_ff,
  output logic flash_wr_valid_ff,
  output logic flash_erase_ff,
  output logic [15:0] flash_addr_ff,
  output logic [7:0] flash_wdata_ff
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bank_reg_addr(input logic [7:0] program_status_word, input logic [2:0] idx);
    bank_reg_addr = {3'b000, program_status_word[BANK_SELECT_HIGH_POS], program_status_word[BANK_SELECT_LOW_POS], idx};
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] pos, input logic v);
    logic [7:0] r;
    r = b;
    r[pos] = v;
    put_bit = r;
  endfunction

  // ----------------------------------------------------------------
  // storage; ram keeps its contents through reset
  // ----------------------------------------------------------------
  logic [7:0] ram_mem [0:255];
  logic [7:0] onchip_external_ram_mem [0:255];
  logic [7:0] nxt_sp, nxt_psw, nxt_rd_data, nxt_ram_addr;
  logic nxt_rd_bit, nxt_rd_valid;
  logic nxt_flash_valid, nxt_flash_erase;
  logic [15:0] nxt_flash_addr;
  logic [7:0] nxt_flash_wdata;
  logic ram_we, onchip_external_ram_we;
  logic [7:0] ram_wd, tgt, cur, wval;
  logic in_sfr, bit_mode;
  logic [2:0] bit_pos;

  // ----------------------------------------------------------------
  // address decode and next state
  // ----------------------------------------------------------------
  always_comb begin
    tgt = 8'h00;
    in_sfr = 1'b0;
    bit_mode = 1'b0;
    bit_pos = 3'h0;
    nxt_sp = stack_pointer_ff;
    case (acc_kind)
      KIND_DIRECT: begin
        tgt = acc_addr;
        in_sfr = acc_addr[7];
      end
      KIND_INDIRECT: begin
        tgt = ram_mem[bank_reg_addr(program_status_word_ff, {2'b00, acc_addr[0]})];
        in_sfr = 1'b0;
      end
      KIND_BIT: begin
        // bit mode comes from the kind alone, whatever the address
        bit_mode = 1'b1;
        bit_pos = acc_addr[2:0];
        if (acc_addr[7]) begin
          tgt = {acc_addr[7:3], 3'b000};
          in_sfr = 1'b1;
        end else begin
          tgt = {BIT_AREA_HI, acc_addr[6:3]};
        end
      end
      KIND_REG: tgt = bank_reg_addr(program_status_word_ff, acc_addr[2:0]);
      KIND_PUSH: begin
        tgt = stack_pointer_ff + 8'h01;
        if (acc_valid) nxt_sp = stack_pointer_ff + 8'h01;
      end
      KIND_POP: begin
        tgt = stack_pointer_ff;
        if (acc_valid) nxt_sp = stack_pointer_ff - 8'h01;
      end
      default: tgt = 8'h00;
    endcase
    // unoccupied register addresses read whatever the outside returns
    if (!in_sfr) begin
      cur = ram_mem[tgt];
    end else if (tgt == STACK_POINTER_ADDR) begin
      cur = stack_pointer_ff;
    end else if (tgt == PROGRAM_STATUS_WORD_ADDR) begin
      cur = program_status_word_ff;
    end else begin
      cur = sfr_rdata;
    end
    wval = bit_mode ? put_bit(cur, bit_pos, acc_wbit) : acc_wdata;
    if (acc_kind == KIND_POP) wval = acc_wdata;
    nxt_psw = program_status_word_ff;
    ram_we = 1'b0;
    ram_wd = wval;
    sfr_valid = 1'b0;
    sfr_write = 1'b0;
    sfr_addr = tgt;
    sfr_wdata = wval;
    onchip_external_ram_we = 1'b0;
    nxt_flash_valid = 1'b0;
    nxt_flash_erase = 1'b0;
    nxt_flash_addr = flash_addr_ff;
    nxt_flash_wdata = flash_wdata_ff;
    nxt_rd_valid = acc_valid && acc_kind != KIND_NONE;
    nxt_rd_data = rd_data_ff;
    nxt_rd_bit = rd_bit_ff;
    nxt_ram_addr = ram_addr_ff;
    if (acc_valid && acc_kind == KIND_ONCHIP_EXTERNAL_RAM) begin
      nxt_rd_data = onchip_external_ram_mem[acc_xaddr[7:0]];
      if (acc_write && program_store_write_enable) begin
        nxt_flash_valid = 1'b1;
        nxt_flash_erase = program_store_erase_enable;
        nxt_flash_addr = acc_xaddr;
        nxt_flash_wdata = acc_wdata;
      end else if (acc_write) begin
        onchip_external_ram_we = 1'b1;
      end
    end else if (acc_valid && acc_kind != KIND_NONE) begin
      nxt_rd_data = cur;
      nxt_rd_bit = cur[bit_pos];
      nxt_ram_addr = tgt;
      if (in_sfr && tgt != STACK_POINTER_ADDR && tgt != PROGRAM_STATUS_WORD_ADDR) begin
        sfr_valid = 1'b1;
        sfr_write = acc_write;
      end
      // a pop only reads, whatever the write qualifier says
      if ((acc_write && acc_kind != KIND_POP) || acc_kind == KIND_PUSH) begin
        if (!in_sfr) begin
          ram_we = 1'b1;
        end else if (tgt == STACK_POINTER_ADDR) begin
          nxt_sp = wval;
        end else if (tgt == PROGRAM_STATUS_WORD_ADDR) begin
          nxt_psw = wval;
        end
      end
      if (acc_kind == KIND_PUSH) ram_wd = acc_wdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stack_pointer_ff <= STACK_POINTER_RESET;
      program_status_word_ff <= PROGRAM_STATUS_WORD_RESET;
      rd_data_ff <= 8'h00;
      rd_bit_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      ram_addr_ff <= 8'h00;
      flash_wr_valid_ff <= 1'b0;
      flash_erase_ff <= 1'b0;
      flash_addr_ff <= 16'h0000;
      flash_wdata_ff <= 8'h00;
    end else begin
      stack_pointer_ff <= nxt_sp;
      program_status_word_ff <= nxt_psw;
      rd_data_ff <= nxt_rd_data;
      rd_bit_ff <= nxt_rd_bit;
      rd_valid_ff <= nxt_rd_valid;
      ram_addr_ff <= nxt_ram_addr;
      flash_wr_valid_ff <= nxt_flash_valid;
      flash_erase_ff <= nxt_flash_erase;
      flash_addr_ff <= nxt_flash_addr;
      flash_wdata_ff <= nxt_flash_wdata;
    end
  end

  // no reset on the arrays: their contents survive a reset
  always_ff @(posedge clk) begin
    if (ram_we) ram_mem[tgt] <= ram_wd;
    if (onchip_external_ram_we) onchip_external_ram_mem[acc_xaddr[7:0]] <= acc_wdata;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_push_pointer: assert property (acc_valid && acc_kind == KIND_PUSH |=>
    stack_pointer_ff == $past(stack_pointer_ff) + 8'h01) else $error("push did not bump pointer");
  chk_push_data: assert property (acc_valid && acc_kind == KIND_PUSH |=>
    ram_mem[stack_pointer_ff] == $past(acc_wdata)) else $error("pushed byte not at new pointer");
  chk_pop_pointer: assert property (acc_valid && acc_kind == KIND_POP |=>
    stack_pointer_ff == $past(stack_pointer_ff) - 8'h01) else $error("pop did not drop pointer");
  chk_bank_reg: assert property (acc_valid && acc_kind == KIND_REG |=>
    ram_addr_ff <= BANK_TOP && ram_addr_ff[4:3] == $past(program_status_word_ff[4:3]) &&
    ram_addr_ff[2:0] == $past(acc_addr[2:0])) else $error("register access missed active bank");
  chk_low_bit_map: assert property (acc_valid && acc_kind == KIND_BIT && !acc_addr[7] |=>
    ram_addr_ff == {BIT_AREA_HI, $past(acc_addr[6:3])}) else $error("low bit address mapped wrong");
  chk_direct_sfr: assert property (acc_valid && acc_kind == KIND_DIRECT && acc_addr[7] &&
    acc_addr != STACK_POINTER_ADDR && acc_addr != PROGRAM_STATUS_WORD_ADDR |-> sfr_valid && sfr_addr == acc_addr)
    else $error("direct high access not sent to registers");
  chk_indirect_ram: assert property (acc_kind == KIND_INDIRECT |-> !sfr_valid)
    else $error("indirect access reached registers");
  chk_sfr_bit: assert property (acc_valid && acc_kind == KIND_BIT && acc_addr[7] |->
    tgt[2:0] == 3'b000 && tgt[7:3] == acc_addr[7:3]) else $error("register bit access misaligned");
  chk_flash_redirect: assert property (acc_valid && acc_kind == KIND_ONCHIP_EXTERNAL_RAM && acc_write |=>
    flash_wr_valid_ff == $past(program_store_write_enable) &&
    flash_erase_ff == ($past(program_store_write_enable) && $past(program_store_erase_enable)))
    else $error("flash redirect wrong");
  chk_onchip_external_ram_mirror: assert property (acc_valid && acc_kind == KIND_ONCHIP_EXTERNAL_RAM && acc_write &&
    !program_store_write_enable |=> onchip_external_ram_mem[$past(acc_xaddr[7:0])] == $past(acc_wdata))
    else $error("external ram write lost");

  cov_push_pop: cover property (acc_valid && acc_kind == KIND_PUSH ##1 acc_valid && acc_kind == KIND_POP);
  cov_bank_switch: cover property (program_status_word_ff[4:3] == 2'b00 ##[1:20] program_status_word_ff[4:3] == 2'b11);
  cov_flash_erase: cover property (flash_wr_valid_ff && flash_erase_ff);
endmodule // data_memory_sfr_decoder

// File: verif/sfr_stub.sv
// far-side register block model answering register-space accesses
`timescale 1ns/1ps
module sfr_stub (
  input wire logic clk,
  input wire logic sfr_valid,
  input wire logic [7:0] sfr_addr,
  output logic [7:0] sfr_rdata
);
  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [7:0] idle_ff = 8'h5A;
  // unselected: pattern flips every cycle so a stale byte never matches
  always @(posedge clk) idle_ff <= ~idle_ff;
  // selected: inverted address, easy to predict; unoccupied addresses are never sent
  assign sfr_rdata = sfr_valid ? ~sfr_addr : idle_ff;
endmodule // sfr_stub

// File: verif/tb_top.sv
// self-checking bench for the data memory decoder
`timescale 1ns/1ps
module tb_top;
  import dmem_pkg::*;
  logic clk, resetn, acc_valid, acc_write, acc_wbit, wr_en, er_en, sfr_valid, sfr_write, rd_bit_ff, rd_valid_ff;
  logic fl_v, fl_e;
  acc_kind_t acc_kind;
  logic [7:0] acc_addr, acc_wdata, sfr_rdata, sfr_addr, sfr_wdata, rd_data_ff, ram_addr_ff, sp_q, psw_q, fl_wd, d, a;
  logic [15:0] acc_xaddr, fl_addr, x;
  int error_cnt = 0, checks_done = 0, seed = 66;
  data_memory_sfr_decoder dut (.clk(clk), .resetn(resetn), .acc_valid(acc_valid), .acc_kind(acc_kind),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_xaddr(acc_xaddr), .acc_wdata(acc_wdata), .acc_wbit(acc_wbit),
    .program_store_write_enable(wr_en), .program_store_erase_enable(er_en), .sfr_rdata(sfr_rdata),
    .sfr_valid(sfr_valid), .sfr_write(sfr_write), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .rd_data_ff(rd_data_ff), .rd_bit_ff(rd_bit_ff), .rd_valid_ff(rd_valid_ff), .ram_addr_ff(ram_addr_ff),
    .stack_pointer_ff(sp_q), .program_status_word_ff(psw_q), .flash_wr_valid_ff(fl_v),
    .flash_erase_ff(fl_e), .flash_addr_ff(fl_addr), .flash_wdata_ff(fl_wd));
  sfr_stub far (.clk(clk), .sfr_valid(sfr_valid), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  // reserved register addresses are kept out of the stimulus
  function automatic logic unused_reg(input logic [7:0] ad);
    case (ad)
      8'h84, 8'h85, 8'h86, 8'h9A, 8'hA7, 8'hAE, 8'hAF, 8'hB0, 8'hBA, 8'hE5, 8'hE7, 8'hF4, 8'hF5: unused_reg = 1'b1;
      default: unused_reg = 1'b0;
    endcase
  endfunction
  // request lands on the next rising edge; comb outputs readable on return
  task automatic acc(input acc_kind_t k, input logic w, input logic [7:0] ad, input logic [7:0] wd = 8'h00,
                     input logic wb = 1'b0, input logic [15:0] xa = 16'h0000);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_kind = k;
    acc_write = w;
    acc_addr = ad;
    acc_wdata = wd;
    acc_wbit = wb;
    acc_xaddr = xa;
    #1;
  endtask
  // previous access has been registered when this returns
  task automatic idle();
    @(negedge clk);
    acc_valid = 1'b0;
    acc_kind = KIND_NONE;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    er_en = 1'b0;
    acc_valid = 1'b0;
    acc_kind = KIND_NONE;
    {acc_write, acc_wbit, acc_addr, acc_wdata, acc_xaddr} = '0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    chk8(sp_q, 8'h07);
    d = 8'($random(seed));
    acc(KIND_PUSH, 1'b0, 8'h00, d);
    idle();
    chk8(ram_addr_ff, 8'h08);
    chk1(rd_valid_ff, 1'b1);
    chk8(sp_q, 8'h08);
    acc(KIND_DIRECT, 1'b1, STACK_POINTER_ADDR, 8'hFF);
    acc(KIND_PUSH, 1'b0, 8'h00, ~d);
    acc(KIND_POP, 1'b0, 8'h00);
    idle();
    chk8(rd_data_ff, ~d);
    chk8(sp_q, 8'hFF);
    $display("stack test done");
    for (int b = 0; b < 4; b++) begin
      acc(KIND_DIRECT, 1'b1, PROGRAM_STATUS_WORD_ADDR, 8'(b << 3));
      chk1(sfr_valid, 1'b0);
      acc(KIND_REG, 1'b1, 8'h02, 8'(b));
      idle();
      chk8(psw_q, 8'(b << 3));
      chk8(ram_addr_ff, 8'(b * 8 + 2));
    end
    d = 8'($random(seed));
    acc(KIND_REG, 1'b1, 8'h01, 8'h85);
    acc(KIND_INDIRECT, 1'b1, 8'h01, d);
    chk1(sfr_valid, 1'b0);
    acc(KIND_INDIRECT, 1'b0, 8'h01);
    idle();
    chk8(ram_addr_ff, 8'h85);
    chk8(rd_data_ff, d);
    acc(KIND_REG, 1'b1, 8'h00, 8'h86);
    acc(KIND_INDIRECT, 1'b0, 8'h00);
    idle();
    chk8(ram_addr_ff, 8'h86);
    $display("bank test done");
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
      acc(KIND_BIT, 1'b1, a, 8'h00, 1'b1);
      acc(KIND_BIT, 1'b0, a);
      idle();
      chk8(ram_addr_ff, 8'h20 + 8'(a[6:3]));
      chk1(rd_bit_ff, 1'b1);
      acc(KIND_BIT, 1'b1, a, 8'h00, 1'b0);
      acc(KIND_DIRECT, 1'b0, 8'h20 + 8'(a[6:3]));
      idle();
      chk1(rd_data_ff[a[2:0]], 1'b0);
    end
    $display("bit test done");
    for (int i = 0; i < 16; i++) begin
      a = {1'b1, 7'($random(seed))};
      if (a == STACK_POINTER_ADDR || a == PROGRAM_STATUS_WORD_ADDR || unused_reg(a)) a = 8'h90;
      if (i < 3) a = (i == 0) ? 8'h9B : 8'h90;
      acc(KIND_DIRECT, 1'b0, a);
      chk1(sfr_valid, 1'b1);
      chk8(sfr_addr, a);
      idle();
      chk8(rd_data_ff, ~a);
    end
    acc(KIND_BIT, 1'b1, 8'hE5, 8'h00, 1'b1);
    chk8(sfr_addr, 8'hE0);
    chk8(sfr_wdata, 8'h3F);
    chk1(sfr_write, 1'b1);
    $display("register space test done");
    x = 16'($random(seed));
    d = 8'($random(seed));
    acc(KIND_ONCHIP_EXTERNAL_RAM, 1'b1, 8'h00, d, 1'b0, x);
    acc(KIND_ONCHIP_EXTERNAL_RAM, 1'b0, 8'h00, 8'h00, 1'b0, {~x[15:8], x[7:0]});
    idle();
    chk8(rd_data_ff, d);
    for (int e = 0; e < 2; e++) begin
      wr_en = 1'b1;
      er_en = e[0];
      acc(KIND_ONCHIP_EXTERNAL_RAM, 1'b1, 8'h00, ~d, 1'b0, x);
      idle();
      chk1(fl_v, 1'b1);
      chk1(fl_e, e[0]);
      chk8(fl_addr[15:8], x[15:8]);
      chk8(fl_addr[7:0], x[7:0]);
      chk8(fl_wd, ~d);
    end
    wr_en = 1'b0;
    er_en = 1'b0;
    acc(KIND_ONCHIP_EXTERNAL_RAM, 1'b0, 8'h00, 8'h00, 1'b0, x);
    idle();
    chk8(rd_data_ff, d);
    chk1(fl_v, 1'b0);
    idle();
    chk1(rd_valid_ff, 1'b0);
    $display("external ram test done");
    end_sim();
  end
endmodule // tb_top
